// ---- core/tcc_unit.sv ----
// 16-bit compare and capture registers with shared high-byte latch
//
// What this block does
// - Each 16-bit compare value is matched against the counter every tick.
// - A match raises an interrupt event and toggles the compare output pin.
// - Compare writes take the high byte from the temp latch, loading both.
// - One temp high-byte latch serves every 16-bit register of the block.
// - A capture pin edge copies the counter into the capture register.
// - On the first timer the capture source may be the comparator output.
// - The capture value can act as counter TOP in selected waveform modes.
// - Capture reads use the temp latch so both bytes match one value.
// - While capture is TOP, the capture pin is ignored.
// - A counter write blocks compare matches on the next timer tick.
// - Match flags set two system clocks after the tick where the counter equals compare.
`timescale 1ns/1ps
module tcc_unit #(
    parameter bit HAS_COMPARATOR_SRC = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [tcc_pkg::TCC_AW-1:0] reg_addr_i,
    input wire logic [tcc_pkg::TCC_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [tcc_pkg::TCC_DW-1:0] reg_rdata_o,
    input wire logic [tcc_pkg::TCC_CW-1:0] counter_value_i,
    input wire logic counter_write_i,
    input wire logic timer_tick_i,
    input wire logic capture_input_pin_i,
    input wire logic comparator_out_i,
    output logic [tcc_pkg::TCC_NUM_CMP-1:0] compare_output_pin_o,
    output logic [tcc_pkg::TCC_NUM_CMP-1:0] compare_match_o,
    output logic capture_event_o,
    output logic top_from_capture_o,
    output logic [tcc_pkg::TCC_CW-1:0] capture_top_o,
    output logic irq_o
);
    import tcc_pkg::*;

    logic [TCC_CW-1:0] cmp [TCC_NUM_CMP];
    logic [TCC_CW-1:0] capture_value_reg;
    logic [TCC_DW-1:0] temp_hi;
    logic [TCC_DW-1:0] next_temp;
    logic [TCC_DW-1:0] ctrl;
    logic [TCC_NUM_EVT-1:0] status;
    logic [TCC_NUM_EVT-1:0] mask;
    logic [TCC_NUM_EVT-1:0] evt_set;
    logic [TCC_NUM_CMP-1:0] cmp_lo_wr;
    logic [TCC_NUM_CMP-1:0] cmp_hi_wr;
    logic [TCC_NUM_CMP-1:0] cmp_lo_rd;
    logic [TCC_NUM_CMP-1:0] match_pulse;
    logic [TCC_MW-1:0] waveform_mode_select;
    logic block_pending;
    logic top_mode;
    logic pin_s1, pin_s2, pin_d;
    logic cmp_s1, cmp_s2, cmp_d;
    logic src_now, src_prev, src_edge, cap_evt, top_reached;
    logic [TCC_DW-1:0] next_rdata;

    assign waveform_mode_select = ctrl[TCC_CTRL_MODE_LSB +: TCC_MW];
    assign top_mode = TCC_CAP_TOP_MODES[waveform_mode_select];
    assign top_from_capture_o = top_mode;
    assign capture_top_o = capture_value_reg;
    assign compare_match_o = match_pulse;

    // Two-stage synchronisers for the asynchronous trigger sources
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
        end else begin
            pin_s1 <= capture_input_pin_i;
            pin_s2 <= pin_s1;
            cmp_s1 <= comparator_out_i;
            cmp_s2 <= cmp_s1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_d <= 1'b0;
            cmp_d <= 1'b0;
        end else begin
            pin_d <= pin_s2;
            cmp_d <= cmp_s2;
        end
    end

    // Source select only exists when the comparator route is built
    assign src_now = (HAS_COMPARATOR_SRC && ctrl[TCC_CTRL_SRC_BIT]) ?
                     cmp_s2 : pin_s2;
    assign src_prev = (HAS_COMPARATOR_SRC && ctrl[TCC_CTRL_SRC_BIT]) ?
                      cmp_d : pin_d;
    assign src_edge = ctrl[TCC_CTRL_EDGE_BIT] ? (src_now && !src_prev) :
                      (!src_now && src_prev);
    assign cap_evt = src_edge && !top_mode;
    assign top_reached = top_mode && timer_tick_i &&
                         (counter_value_i == capture_value_reg);

    // Register decode
    genvar gi;
    generate
        for (gi = 0; gi < TCC_NUM_CMP; gi++) begin : g_dec
            localparam logic [TCC_AW-1:0] LO =
                TCC_AW'(TCC_OFS_CMP_A_LO + TCC_CMP_STRIDE * gi);
            localparam logic [TCC_AW-1:0] HI = TCC_AW'(LO + 4'h1);
            assign cmp_lo_wr[gi] = reg_wr_i && (reg_addr_i == LO);
            assign cmp_hi_wr[gi] = reg_wr_i && (reg_addr_i == HI);
            assign cmp_lo_rd[gi] = reg_rd_i && (reg_addr_i == LO);
        end
    endgenerate

    // Shared high-byte latch: loaded by any high write or low read
    always_comb begin
        next_temp = temp_hi;
        if (reg_wr_i && (|cmp_hi_wr || reg_addr_i == TCC_OFS_CAP_HI)) begin
            next_temp = reg_wdata_i;
        end
        if (reg_rd_i && reg_addr_i == TCC_OFS_CAP_LO) begin
            next_temp = capture_value_reg[TCC_CW-1:TCC_DW];
        end
        for (int i = 0; i < TCC_NUM_CMP; i++) begin
            if (cmp_lo_rd[i]) begin
                next_temp = cmp[i][TCC_CW-1:TCC_DW];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            temp_hi <= TCC_RST_BYTE;
        end else begin
            temp_hi <= next_temp;
        end
    end

    // Counter write suppresses the match on the next tick
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            block_pending <= 1'b0;
        end else if (counter_write_i) begin
            block_pending <= 1'b1;
        end else if (timer_tick_i) begin
            block_pending <= 1'b0;
        end
    end

    // Per-channel compare register, matcher and waveform pin
    generate
        for (gi = 0; gi < TCC_NUM_CMP; gi++) begin : g_cmp
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    cmp[gi] <= TCC_RST_WORD;
                end else if (cmp_lo_wr[gi]) begin
                    cmp[gi] <= {temp_hi, reg_wdata_i};
                end
            end

            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    match_pulse[gi] <= 1'b0;
                end else begin
                    match_pulse[gi] <= timer_tick_i && !block_pending &&
                        !counter_write_i &&
                        (counter_value_i == cmp[gi]);
                end
            end

            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    compare_output_pin_o[gi] <= 1'b0;
                end else if (match_pulse[gi]) begin
                    compare_output_pin_o[gi] <=
                        !compare_output_pin_o[gi];
                end
            end
        end
    endgenerate

    // Capture register: pin event wins over a CPU write
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            capture_value_reg <= TCC_RST_WORD;
        end else if (cap_evt) begin
            capture_value_reg <= counter_value_i;
        end else if (reg_wr_i && reg_addr_i == TCC_OFS_CAP_LO) begin
            capture_value_reg <= {temp_hi, reg_wdata_i};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            capture_event_o <= 1'b0;
        end else begin
            capture_event_o <= cap_evt;
        end
    end

    // Control and mask registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl <= TCC_RST_BYTE;
        end else if (reg_wr_i && reg_addr_i == TCC_OFS_CTRL) begin
            ctrl <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask <= TCC_RST_EVT;
        end else if (reg_wr_i && reg_addr_i == TCC_OFS_MASK) begin
            mask <= reg_wdata_i[TCC_NUM_EVT-1:0];
        end
    end

    // Sticky events, write one to clear, set wins
    assign evt_set = {cap_evt || top_reached, match_pulse};
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status <= TCC_RST_EVT;
        end else if (reg_wr_i && reg_addr_i == TCC_OFS_STATUS) begin
            status <= (status & ~reg_wdata_i[TCC_NUM_EVT-1:0]) | evt_set;
        end else begin
            status <= status | evt_set;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status & mask);
        end
    end

    // Read data, valid only the cycle after the strobe
    always_comb begin
        next_rdata = TCC_RST_BYTE;
        if (reg_addr_i == TCC_OFS_CAP_LO) begin
            next_rdata = capture_value_reg[TCC_DW-1:0];
        end else if (reg_addr_i == TCC_OFS_CAP_HI) begin
            next_rdata = temp_hi;
        end else if (reg_addr_i == TCC_OFS_CTRL) begin
            next_rdata = ctrl;
        end else if (reg_addr_i == TCC_OFS_STATUS) begin
            next_rdata = TCC_DW'(status);
        end else if (reg_addr_i == TCC_OFS_MASK) begin
            next_rdata = TCC_DW'(mask);
        end
        for (int i = 0; i < TCC_NUM_CMP; i++) begin
            if (cmp_lo_rd[i]) begin
                next_rdata = cmp[i][TCC_DW-1:0];
            end
            if (reg_addr_i ==
                TCC_AW'(TCC_OFS_CMP_A_LO + TCC_CMP_STRIDE * i + 1)) begin
                next_rdata = temp_hi;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= TCC_RST_BYTE;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= TCC_RST_BYTE;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_compare_eq;
        timer_tick_i && !block_pending && !counter_write_i &&
        counter_value_i == cmp[0] |=> match_pulse[0];
    endproperty
    a_compare_eq: assert property (p_compare_eq)
        else $error("compare A equality missed");

    property p_pin_toggle;
        match_pulse[1] |=> compare_output_pin_o[1] !=
                           $past(compare_output_pin_o[1]);
    endproperty
    a_pin_toggle: assert property (p_pin_toggle)
        else $error("compare B pin did not toggle");

    property p_atomic_write;
        cmp_hi_wr[0] ##1 cmp_lo_wr[0] && !reg_rd_i
        |=> cmp[0] == {$past(reg_wdata_i, 2), $past(reg_wdata_i)};
    endproperty
    a_atomic_write: assert property (p_atomic_write)
        else $error("compare A not loaded as one word");

    property p_shared_temp;
        reg_wr_i && reg_addr_i == TCC_OFS_CAP_HI |=>
        temp_hi == $past(reg_wdata_i);
    endproperty
    a_shared_temp: assert property (p_shared_temp)
        else $error("capture high write missed shared latch");

    property p_capture;
        cap_evt |=> capture_value_reg == $past(counter_value_i) &&
                    capture_event_o;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not sample counter");

    property p_no_cap_top;
        top_mode && !(reg_wr_i && reg_addr_i == TCC_OFS_CAP_LO) |=>
        capture_value_reg == $past(capture_value_reg);
    endproperty
    a_no_cap_top: assert property (p_no_cap_top)
        else $error("capture while capture is TOP");

    property p_block;
        counter_write_i ##1 timer_tick_i |=> match_pulse == 3'h0;
    endproperty
    a_block: assert property (p_block)
        else $error("match not blocked after counter write");

    property p_flag;
        match_pulse[2] |=> status[2];
    endproperty
    a_flag: assert property (p_flag)
        else $error("compare C flag not set");

    property p_read_pair;
        reg_rd_i && reg_addr_i == TCC_OFS_CAP_LO ##1
        reg_rd_i && reg_addr_i == TCC_OFS_CAP_HI
        |=> reg_rdata_o == $past(capture_value_reg[TCC_CW-1:TCC_DW], 2);
    endproperty
    a_read_pair: assert property (p_read_pair)
        else $error("capture high byte not from latch");

    property p_low_read;
        cmp_lo_rd[1] |=> temp_hi == $past(cmp[1][TCC_CW-1:TCC_DW]);
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("low read did not load latch");

    c_match: cover property (match_pulse[0] ##1 irq_o);
    c_capture: cover property (cap_evt ##1 status[TCC_ST_CAP_BIT]);
    c_top: cover property (top_mode && top_reached);
    c_blocked: cover property (counter_write_i ##1 timer_tick_i);
endmodule

// ---- core/tcc_pkg.sv ----
// Register map, field layout and reset values of the compare/capture unit
package tcc_pkg;
    localparam int TCC_AW = 4;
    localparam int TCC_DW = 8;
    localparam int TCC_CW = 16;
    localparam int TCC_NUM_CMP = 3;
    localparam int TCC_MW = 4;

    // Byte offsets: compare x low at A_LO + x * stride, high one above
    localparam logic [TCC_AW-1:0] TCC_OFS_CMP_A_LO = 4'h0;
    localparam logic [TCC_AW-1:0] TCC_CMP_STRIDE = 4'h2;
    localparam logic [TCC_AW-1:0] TCC_OFS_CAP_LO = 4'h6;
    localparam logic [TCC_AW-1:0] TCC_OFS_CAP_HI = 4'h7;
    localparam logic [TCC_AW-1:0] TCC_OFS_CTRL = 4'h8;
    localparam logic [TCC_AW-1:0] TCC_OFS_STATUS = 4'h9;
    localparam logic [TCC_AW-1:0] TCC_OFS_MASK = 4'ha;

    // Control fields
    localparam int TCC_CTRL_SRC_BIT = 0;
    localparam int TCC_CTRL_EDGE_BIT = 1;
    localparam int TCC_CTRL_MODE_LSB = 4;

    // Status and mask: bits 0..2 compare A..C, bit 3 capture
    localparam int TCC_ST_CAP_BIT = 3;
    localparam int TCC_NUM_EVT = 4;

    localparam logic [TCC_DW-1:0] TCC_RST_BYTE = 8'h00;
    localparam logic [TCC_CW-1:0] TCC_RST_WORD = 16'h0000;
    localparam logic [TCC_NUM_EVT-1:0] TCC_RST_EVT = 4'h0;

    // One bit per waveform mode; set where the capture value is TOP
    localparam logic [15:0] TCC_CAP_TOP_MODES = 16'h5500;
endpackage

// ---- test/tcc_timer_model.sv ----
// Counter and timer tick source standing beside the unit
`timescale 1ns/1ps
module tcc_timer_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic load_i,
    input wire logic [tcc_pkg::TCC_CW-1:0] load_val_i,
    output logic [tcc_pkg::TCC_CW-1:0] counter_value_o,
    output logic timer_tick_o,
    output logic counter_write_o
);
    import tcc_pkg::*;
    // A load wins over counting and is flagged as a counter write
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            counter_value_o <= TCC_RST_WORD;
            timer_tick_o <= 1'b0;
            counter_write_o <= 1'b0;
        end else begin
            timer_tick_o <= run_i;
            counter_write_o <= load_i;
            if (load_i) begin
                counter_value_o <= load_val_i;
            end else if (timer_tick_o) begin
                counter_value_o <= counter_value_o + 16'h0001;
            end
        end
    end
endmodule

// ---- test/tcc_unit_tb.sv ----
// Self-checking bench of the compare and capture unit
`timescale 1ns/1ps
module tcc_unit_tb;
    import tcc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [TCC_AW-1:0] addr = '0;
    logic [TCC_DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [TCC_DW-1:0] rdata;
    logic run = 1'b0;
    logic load = 1'b0;
    logic [TCC_CW-1:0] load_val = '0;
    logic [TCC_CW-1:0] cnt;
    logic tick;
    logic cwr;
    logic cap_pin = 1'b0;
    logic cmp_out = 1'b0;
    logic [TCC_NUM_CMP-1:0] pins;
    logic [TCC_NUM_CMP-1:0] match;
    logic cap_evt;
    logic top;
    logic [TCC_CW-1:0] cap_top;
    logic irq;
    int n_mismatch = 0;
    int check_count = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    tcc_timer_model u_tmr (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .run_i(run), .load_i(load), .load_val_i(load_val),
        .counter_value_o(cnt), .timer_tick_o(tick), .counter_write_o(cwr));
    tcc_unit u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .counter_value_i(cnt),
        .counter_write_i(cwr), .timer_tick_i(tick),
        .capture_input_pin_i(cap_pin), .comparator_out_i(cmp_out),
        .compare_output_pin_o(pins), .compare_match_o(match),
        .capture_event_o(cap_evt), .top_from_capture_o(top),
        .capture_top_o(cap_top), .irq_o(irq));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
            input string msg);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg,
                got, exp);
        end
    endtask
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rd8(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata;
    endtask
    // Back-to-back byte pairs: high first on write, low first on read
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys_i);
        addr <= a + 4'h1;
        wdata <= v[15:8];
        wr <= 1'b1;
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= v[7:0];
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        addr <= a + 4'h1;
        @(negedge clk_sys_i);
        v[7:0] = rdata;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        @(negedge clk_sys_i);
        v[15:8] = rdata;
    endtask
    task automatic set_cnt(input logic [15:0] v, input logic r);
        @(posedge clk_sys_i);
        load <= 1'b1;
        load_val <= v;
        run <= r;
        @(posedge clk_sys_i);
        load <= 1'b0;
    endtask
    // Looks for an event pulse over a fixed span; sel 3 is capture
    task automatic wait_ev(input int sel, input logic exp, input string m);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(negedge clk_sys_i);
            if (sel == 3 ? cap_evt === 1'b1 : match[sel] === 1'b1) begin
                seen = 1'b1;
            end
        end
        chk(seen, exp, m);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        logic [7:0] b;
        logic [15:0] w;
        logic [3:0] a;
        repeat (10) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        wr8(4'hf, 8'h5a);
        for (int i = 0; i < 16; i++) begin
            rd8(4'(i), b);
            chk(b, 16'h0000, "reset or unmapped read");
        end
        $display("test reset_map done");
        for (int x = 0; x < 3; x++) begin
            a = TCC_OFS_CMP_A_LO + TCC_CMP_STRIDE * 4'(x);
            wr16(a, 16'h0040 + 16'(x));
            rd16(a, w);
            chk(w, 16'h0040 + 16'(x), "compare readback");
        end
        wr8(TCC_OFS_CAP_HI, 8'h9c);
        wr8(4'h2, 8'h11);
        rd16(4'h2, w);
        chk(w, 16'h9c11, "latch shared on write");
        wr16(4'h2, 16'h0041);
        $display("test access done");
        wr8(TCC_OFS_MASK, 8'h0f);
        set_cnt(16'h003c, 1'b1);
        wait_ev(0, 1'b1, "compare a match");
        chk(pins, 16'h0007, "compare pins toggled");
        rd8(TCC_OFS_STATUS, b);
        chk(b, 16'h0007, "compare flags");
        chk(irq, 16'h0001, "irq unmasked");
        set_cnt(16'h0000, 1'b0);
        wr8(TCC_OFS_STATUS, 8'h07);
        rd8(TCC_OFS_STATUS, b);
        chk(b, 16'h0000, "flags cleared");
        chk(irq, 16'h0000, "irq after clear");
        wr8(TCC_OFS_MASK, 8'h00);
        set_cnt(16'h003c, 1'b1);
        wait_ev(1, 1'b1, "compare b match");
        chk(irq, 16'h0000, "irq masked");
        chk(pins, 16'h0000, "pins toggled back");
        set_cnt(16'h0040, 1'b1);
        wait_ev(0, 1'b0, "match after counter write");
        set_cnt(16'h003e, 1'b1);
        wait_ev(0, 1'b1, "match with no write");
        set_cnt(16'h0000, 1'b0);
        wr8(TCC_OFS_STATUS, 8'h0f);
        $display("test compare done");
        wr8(TCC_OFS_CTRL, 8'h02);
        set_cnt(16'h1234, 1'b0);
        @(posedge clk_sys_i) cap_pin <= 1'b1;
        wait_ev(3, 1'b1, "capture rising");
        rd8(TCC_OFS_CAP_LO, b);
        chk(b, 16'h0034, "capture low");
        set_cnt(16'habcd, 1'b0);
        @(posedge clk_sys_i) cap_pin <= 1'b0;
        wait_ev(3, 1'b0, "falling ignored");
        @(posedge clk_sys_i) cap_pin <= 1'b1;
        wait_ev(3, 1'b1, "second capture");
        rd8(TCC_OFS_CAP_HI, b);
        chk(b, 16'h0012, "high from latch");
        rd16(TCC_OFS_CAP_LO, w);
        chk(w, 16'habcd, "capture word");
        rd8(4'h1, b);
        chk(b, 16'h00ab, "any high read gives latch");
        rd8(TCC_OFS_STATUS, b);
        chk(b, 16'h0008, "capture flag");
        wr8(TCC_OFS_STATUS, 8'h08);
        $display("test capture done");
        wr8(TCC_OFS_CTRL, 8'h01);
        set_cnt(16'h0777, 1'b0);
        @(posedge clk_sys_i) cmp_out <= 1'b1;
        wait_ev(3, 1'b0, "comparator rising ignored");
        @(posedge clk_sys_i) cap_pin <= 1'b0;
        wait_ev(3, 1'b0, "pin ignored");
        @(posedge clk_sys_i) cmp_out <= 1'b0;
        wait_ev(3, 1'b1, "comparator capture");
        rd16(TCC_OFS_CAP_LO, w);
        chk(w, 16'h0777, "comparator value");
        $display("test comparator done");
        for (int m = 0; m < 16; m++) begin
            wr8(TCC_OFS_CTRL, {4'(m), 4'h2});
            @(negedge clk_sys_i);
            chk(top, 16'(TCC_CAP_TOP_MODES[m]), "top select");
        end
        wr8(TCC_OFS_CTRL, 8'h82);
        @(negedge clk_sys_i);
        chk(cap_top, 16'h0777, "top value");
        wr8(TCC_OFS_STATUS, 8'h0f);
        @(posedge clk_sys_i) cap_pin <= 1'b1;
        wait_ev(3, 1'b0, "pin off in top mode");
        set_cnt(16'h0770, 1'b1);
        repeat (15) @(negedge clk_sys_i);
        set_cnt(16'h0000, 1'b0);
        rd8(TCC_OFS_STATUS, b);
        chk(b & 8'h08, 16'h0008, "flag at top");
        rd16(TCC_OFS_CAP_LO, w);
        chk(w, 16'h0777, "capture kept in top mode");
        $display("test top done");
        finish_test();
    end
endmodule
